// ---- verilog/adc_readout_pkg.sv ----
package adc_readout_pkg;
   // ==========================================================
   // result word
   // ==========================================================
   localparam int RESULT_W = 16;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   // twos complement is straight binary with the top bit flipped
   localparam logic [15:0] TWOS_FLIP = 16'h8000;
   localparam int MSB_POS = 15;
   localparam logic [3:0] LSB_INDEX = 4'hf;
   localparam logic [3:0] INDEX_RESET = 4'h0;
   localparam logic [3:0] INDEX_STEP = 4'h1;
   // ==========================================================
   // timing
   // ==========================================================
   localparam int MCLK_PERIOD_PS = 40000;
   localparam int CONV_TIME_MAX_NS = 1160;
   localparam int THROUGHPUT_KHZ = 600;
   localparam int SCLK_MAX_MHZ = 40;
   // longest time: round down, never below one cycle
   localparam int CONV_CYCLES_RAW = (CONV_TIME_MAX_NS * 1000) / MCLK_PERIOD_PS;
   localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] COUNT_RESET = 6'h00;
   localparam logic [CNT_W-1:0] COUNT_STEP = 6'h01;
   localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
   localparam int SYNC_STAGES = 2;
endpackage

// ---- verilog/sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flip-flop level synchroniser
// ==========================================================
module sync2
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   // first stage is read only by the second
   always_comb
   begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   assign q = st.s2;
endmodule
`default_nettype wire

// ---- verilog/adc_serial_result_readout.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_readout
   import adc_readout_pkg::*;
#(
   parameter int CONV_COUNT = CONV_CYCLES
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic frame_sync_in,
   input wire logic convert_start_n,
   input wire logic output_format_select,
   input wire logic [RESULT_W-1:0] sample_code,
   output logic serial_result_out,
   output logic busy
);
   // ==========================================================
   // conversion side, on mclk
   // ==========================================================
   typedef struct packed
   {
      logic qual;
      logic qual_prev;
      logic busy;
      logic [CNT_W-1:0] count;
      logic [RESULT_W-1:0] code;
      logic [RESULT_W-1:0] result;
   } conv_state_t;

   localparam logic [CNT_W-1:0] conv_last = CNT_W'(CONV_COUNT - 1);

   conv_state_t cv;
   conv_state_t next_cv;
   logic cs_n_m;
   logic convert_start_n_m;
   logic format_m;
   logic [RESULT_W-1:0] code_m;

   sync2 #(.W(1)) u_sync_cs
   (
      .clk(mclk),
      .d(cs_n),
      .q(cs_n_m)
   );

   sync2 #(.W(1)) u_sync_convert_start_n
   (
      .clk(mclk),
      .d(convert_start_n),
      .q(convert_start_n_m)
   );

   sync2 #(.W(1)) u_sync_fmt
   (
      .clk(mclk),
      .d(output_format_select),
      .q(format_m)
   );

   // the analog stand-in is a word from outside; it is sampled at
   // conversion start and must be steady around that edge
   sync2 #(.W(RESULT_W)) u_sync_code
   (
      .clk(mclk),
      .d(sample_code),
      .q(code_m)
   );

   always_comb
   begin
      next_cv = cv;
      // convert start is only seen through chip select low
      if (!cs_n_m)
      begin
         next_cv.qual = convert_start_n_m;
      end
      next_cv.qual_prev = cv.qual;
      if (!cv.busy)
      begin
         if (cv.qual_prev && !cv.qual)
         begin
            next_cv.busy = 1'b1;
            next_cv.count = COUNT_RESET;
            next_cv.code = code_m;
         end
      end
      else
      begin
         if (cv.count == conv_last)
         begin
            next_cv.busy = 1'b0;
            if (format_m)
            begin
               next_cv.result = cv.code ^ TWOS_FLIP;
            end
            else
            begin
               next_cv.result = cv.code;
            end
         end
         else
         begin
            next_cv.count = cv.count + COUNT_STEP;
         end
      end
      if (reset)
      begin
         next_cv.qual = 1'b1;
         next_cv.qual_prev = 1'b1;
         next_cv.busy = 1'b0;
         next_cv.count = COUNT_RESET;
         next_cv.code = RESULT_RESET;
         next_cv.result = RESULT_RESET;
      end
   end

   always_ff @(posedge mclk)
   begin
      cv <= next_cv;
   end

   assign busy = cv.busy;

   // ==========================================================
   // link side, on sclk, cs_n and frame_sync_in edges
   // ==========================================================
   // reads only take the held result from the conversion side, so nothing here can
   // reach the conversion state machine
   typedef struct packed
   {
      logic [3:0] index;
   } shift_state_t;

   typedef struct packed
   {
      logic armed;
      logic fs_mode;
      logic cs_seen;
      logic fs_seen;
      logic [RESULT_W-1:0] snapshot;
   } frame_state_t;

   typedef struct packed
   {
      logic fs_tog;
   } fs_edge_state_t;

   typedef struct packed
   {
      logic cs_tog;
   } edge_state_t;

   shift_state_t sh;
   shift_state_t next_sh;
   frame_state_t fr;
   frame_state_t next_fr;
   edge_state_t ed;
   edge_state_t next_ed;
   fs_edge_state_t fe;
   fs_edge_state_t next_fe;
   logic reset_l;
   logic cs_restart;
   logic fs_restart;
   logic fs_hold;
   logic armed_now;

   sync2 #(.W(1)) u_sync_rst
   (
      .clk(sclk),
      .d(reset),
      .q(reset_l)
   );

   // the held result is read straight from the conversion side: it
   // only changes at busy fall, and hosts start no frame near that
   // edge; a toggle handshake would stall while sclk is stopped

   // deselect seen even with sclk stopped
   always_comb
   begin
      next_ed = ed;
      next_ed.cs_tog = ~ed.cs_tog;
      if (reset)
      begin
         next_ed.cs_tog = 1'b0;
      end
   end

   always_ff @(posedge cs_n)
   begin
      ed <= next_ed;
   end

   assign cs_restart = ed.cs_tog ^ fr.cs_seen;

   // frame sync rise seen with sclk stopped
   always_comb
   begin
      next_fe = fe;
      next_fe.fs_tog = ~fe.fs_tog;
      if (reset)
      begin
         next_fe.fs_tog = 1'b0;
      end
   end

   always_ff @(posedge frame_sync_in)
   begin
      fe <= next_fe;
   end

   assign fs_restart = fe.fs_tog ^ fr.fs_seen;
   // a fresh select overrides a remembered frame sync mode
   assign fs_hold = fr.fs_mode && frame_sync_in && !cs_restart;

   // in frame sync mode, frame sync high holds the frame at its msb
   // spi framing relies on frame sync held high
   assign armed_now = fr.armed && !cs_n && !cs_restart && !fs_restart && !fs_hold;

   always_comb
   begin
      next_fr = fr;
      next_fr.cs_seen = ed.cs_tog;
      next_fr.fs_seen = fe.fs_tog;
      if (!frame_sync_in)
      begin
         next_fr.fs_mode = 1'b1;
      end
      else if (cs_restart)
      begin
         next_fr.fs_mode = 1'b0;
      end
      // msb first, shifting from first falling edge
      // same once frame sync has fallen
      if (!cs_n && !fs_hold)
      begin
         if (!armed_now)
         begin
            next_fr.snapshot = cv.result;
         end
         next_fr.armed = 1'b1;
      end
      else
      begin
         next_fr.armed = 1'b0;
      end
      if (reset_l)
      begin
         next_fr.armed = 1'b0;
         next_fr.fs_mode = 1'b0;
         next_fr.cs_seen = ed.cs_tog;
         next_fr.fs_seen = fe.fs_tog;
         next_fr.snapshot = RESULT_RESET;
      end
   end

   always_ff @(negedge sclk)
   begin
      fr <= next_fr;
   end

   always_comb
   begin
      next_sh = sh;
      if (armed_now)
      begin
         if (sh.index != LSB_INDEX)
         begin
            next_sh.index = sh.index + INDEX_STEP;
         end
      end
      else
      begin
         next_sh.index = INDEX_RESET;
      end
      if (reset_l)
      begin
         next_sh.index = INDEX_RESET;
      end
   end

   // one flop stage per sclk edge
   always_ff @(posedge sclk)
   begin
      sh <= next_sh;
   end

   // ==========================================================
   // serial output
   // ==========================================================
   // outside an armed frame the pin follows the held msb, so a
   // busy fall with frame sync high shows the new msb at once
   // read any time, previous result
   always_comb
   begin
      if (!armed_now)
      begin
         serial_result_out = cv.result[MSB_POS];
      end
      else
      begin
         serial_result_out = fr.snapshot[LSB_INDEX - sh.index];
      end
   end
endmodule
`default_nettype wire

// ---- bench/readout_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// readout checks
// ====================
module readout_props
   import adc_readout_pkg::*;
#(
   parameter int CONV_COUNT = 29
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic frame_sync_in,
   input wire logic convert_start_n,
   input wire logic output_format_select,
   input wire logic [RESULT_W-1:0] sample_code,
   input wire logic serial_result_out,
   input wire logic busy
);
   logic [5:0] cnt;
   logic [15:0] cap;
   logic [15:0] held;
   logic top;
   // own coded copy of the held word, taken on the last busy cycle
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         cnt <= 6'h00;
         held <= 16'h0000;
      end
      else
      begin
         cnt <= busy ? cnt + 6'h01 : 6'h00;
         held <= (busy && cnt == CONV_COUNT - 1) ? (cap ^ (output_format_select ? TWOS_FLIP : 16'h0000)) : held;
      end
      cap <= $rose(busy) ? sample_code : cap;
   end
   assign top = held[15];
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   busy_max_a: assert property (busy |-> cnt < CONV_COUNT)
      else $error("busy too long");
   busy_hold_a: assert property (busy && cnt < CONV_COUNT - 1 |=> busy)
      else $error("busy dropped early");
   busy_end_a: assert property ($fell(busy) |-> cnt == CONV_COUNT)
      else $error("conversion length wrong");
   conv_start_a: assert property ($fell(convert_start_n) && !cs_n && !busy |-> ##[2:6] $rose(busy))
      else $error("conversion did not start");
   start_cause_a: assert property ($rose(busy) |-> !$past(convert_start_n, 2))
      else $error("busy without convert start");
   no_spur_a: assert property (convert_start_n [*6] ##0 !busy |=> !busy)
      else $error("spurious conversion");
   cs_msb_a: assert property ($fell(cs_n) && frame_sync_in |-> serial_result_out == top)
      else $error("msb missing at select");
   fs_msb_a: assert property ($rose(frame_sync_in) |-> serial_result_out == top)
      else $error("msb missing at frame sync");
   cover property ($fell(busy) && frame_sync_in);
   cover property ($rose(frame_sync_in));
   cover property ($fell(cs_n));
endmodule
`default_nettype wire

// ---- bench/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// host serial port
// ====================
module host_model
(
   input wire logic serial_result_out,
   output logic sclk,
   output logic cs_n,
   output logic frame_sync_in
);
   task pulse();
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
   endtask
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b0;
      frame_sync_in = 1'b0;
      #53 cs_n = 1'b1;
      frame_sync_in = 1'b1;
      repeat (3) pulse();
      cs_n = 1'b0;
   end
   // first pulse only arms the frame
   task get(input logic fsm, input int n, output logic [15:0] w);
      int i;
      // frames start clear of busy fall
      if (fsm && !frame_sync_in)
         frame_sync_in = 1'b1;
      else
      begin
         cs_n = 1'b1;
         frame_sync_in = 1'b1;
      end
      #50 cs_n = 1'b0;
      #45 w = {15'h0000, serial_result_out};
      frame_sync_in = !fsm;
      pulse();
      for (i = 1; i < n; i++)
      begin
         pulse();
         w = {w[14:0], serial_result_out};
      end
   endtask
endmodule
`default_nettype wire

// ---- bench/adc_serial_result_readout_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// readout bench
// ====================
module adc_serial_result_readout_test
   import adc_readout_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic convert_start_n = 1'b1;
   logic output_format_select = 1'b0;
   logic [15:0] sample_code = 16'h0000;
   logic [15:0] want = 16'h0000;
   logic [15:0] w;
   wire sclk, cs_n, frame_sync_in, serial_result_out, busy;
   int n_errors = 0;
   int n_checks = 0;
   always #20 mclk = ~mclk;
   adc_serial_result_readout #(.CONV_COUNT(8)) dut (.mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
      .frame_sync_in(frame_sync_in), .convert_start_n(convert_start_n),
      .output_format_select(output_format_select), .sample_code(sample_code),
      .serial_result_out(serial_result_out), .busy(busy));
   host_model host (.serial_result_out(serial_result_out), .sclk(sclk), .cs_n(cs_n),
      .frame_sync_in(frame_sync_in));
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task complete_run();
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounded waits: a stuck busy shows up as a mismatch, not a hang
   task convert(input logic [15:0] code);
      int i;
      sample_code = code;
      repeat (2) @(negedge mclk);
      convert_start_n = 1'b0;
      for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge mclk);
      chk({15'h0000, busy}, 16'h0001);
      for (i = 0; i < 20 && busy === 1'b1; i++) @(negedge mclk);
      chk({15'h0000, busy}, 16'h0000);
      convert_start_n = 1'b1;
      want = code ^ (output_format_select ? TWOS_FLIP : 16'h0000);
   endtask
   task t_codes();
      logic [15:0] c [4] = '{16'hffff, 16'h8000, 16'h0000, 16'ha5c3};
      int k;
      for (k = 0; k < 8; k++)
      begin
         output_format_select = k[2];
         convert(c[k[1:0]]);
         host.get(k[0], 16, w);
         chk(w, want);
      end
   endtask
   task t_latency();
      output_format_select = 1'b0;
      convert(16'h1234);
      fork
         convert(16'hedcb);
         #300 host.get(1'b1, 16, w);
      join
      chk(w, 16'h1234);
      host.get(1'b1, 16, w);
      chk(w, want);
   endtask
   task t_restart();
      int m;
      for (m = 0; m < 2; m++)
      begin
         host.get(m[0], 5, w);
         host.get(m[0], 16, w);
         chk(w, want);
      end
   endtask
   task t_reload();
      host.frame_sync_in = 1'b1;
      convert(16'h0f0f);
      chk({15'h0000, serial_result_out}, {15'h0000, want[15]});
   endtask
   task t_tail();
      host.get(1'b0, 18, w);
      chk(w, {want[13:0], {2{want[0]}}});
   endtask
   task t_gate();
      host.cs_n = 1'b1;
      repeat (6) host.pulse();
      chk({15'h0000, busy}, 16'h0000);
      host.get(1'b0, 16, w);
      chk(w, want);
   endtask
   initial
   begin
      repeat (10) @(negedge mclk);
      reset = 1'b0;
      // link side leaves reset only on sclk edges
      host.cs_n = 1'b1;
      repeat (3) host.pulse();
      host.cs_n = 1'b0;
      repeat (3) @(negedge mclk);
      t_codes();
      t_latency();
      t_restart();
      t_reload();
      t_tail();
      t_gate();
      complete_run();
   end
   initial
   begin
      #100000;
      n_errors++;
      complete_run();
   end
endmodule
bind adc_serial_result_readout readout_props #(.CONV_COUNT(CONV_COUNT)) props (.mclk(mclk), .reset(reset),
   .sclk(sclk), .cs_n(cs_n), .frame_sync_in(frame_sync_in), .convert_start_n(convert_start_n),
   .output_format_select(output_format_select), .sample_code(sample_code),
   .serial_result_out(serial_result_out), .busy(busy));
`default_nettype wire
